// *** hw/cmps_pkg.sv ***
// Purpose: shared constants for the core mode and privilege state block
// Assumes: 32-bit data words
// Notes:   special register selects are local encodings of the mover port
package cmps_pkg;

  // ==========================================================
  // special register selects
  localparam logic [3:0] SEL_PSW       = 4'h0;
  localparam logic [3:0] SEL_IEPSW     = 4'h1;
  localparam logic [3:0] SEL_IAPSW     = 4'h2;
  localparam logic [3:0] SEL_EAPSW     = 4'h3;
  localparam logic [3:0] SEL_FLAGS     = 4'h4;
  localparam logic [3:0] SEL_EXCNUM    = 4'h5;
  localparam logic [3:0] SEL_EXECST    = 4'h6;
  localparam logic [3:0] SEL_MAIN_SP   = 4'h8;
  localparam logic [3:0] SEL_PROC_SP   = 4'h9;
  localparam logic [3:0] SEL_PMASK     = 4'ha;
  localparam logic [3:0] SEL_CONTROL   = 4'he;

  // ==========================================================
  // field positions
  localparam int FLAG_LO      = 28;
  localparam int TBIT_POS     = 24;
  localparam int EXC_W        = 6;
  localparam int MASK_POS     = 0;
  localparam int USER_POS     = 0;
  localparam int STACK_POS    = 1;

  // ==========================================================
  // vectors and reset values
  localparam logic [31:0] VEC_SP_ADDR    = 32'h0000_0000;
  localparam logic [31:0] VEC_RESET_ADDR = 32'h0000_0004;
  localparam logic [31:0] WORD_BYTES     = 32'h0000_0004;
  localparam logic [5:0]  EXC_THREAD     = 6'h00;
  localparam logic [5:0]  EXC_HARD_FAULT = 6'h03;
  localparam logic [5:0]  EXC_SUPCALL    = 6'h0b;
  localparam logic [5:0]  EXC_CFG_FIRST  = 6'h04;

  // ==========================================================
  // core sequencer states
  typedef enum logic [4:0]
  {
    ST_FETCH_SP = 5'b00001,
    ST_FETCH_PC = 5'b00010,
    ST_RUN      = 5'b00100,
    ST_HANDLER  = 5'b01000,
    ST_LOCKUP   = 5'b10000
  } cmps_state_type;

endpackage : cmps_pkg

// *** hw/cmps_reset_sync.sv ***
// Purpose: two-stage release of the asynchronous core reset
// Assumes: rst_n_in may drop at any time
// Notes:   assertion is immediate, release is synchronous
`timescale 1ns/100ps
module cmps_reset_sync
(
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  output logic      rst_n_out
);

  logic stage1;
  logic stage2;

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end
    else
    begin
      stage1 <= 1'b1;
      stage2 <= stage1;
    end
  end

  assign rst_n_out = stage2;

endmodule : cmps_reset_sync

// *** hw/cmps_stack_unit.sv ***
// Purpose: main and process stack pointers with full-descending push
// Assumes: one push, pop or load per cycle at most
// Notes:   pointer low two bits forced to zero, word aligned
`timescale 1ns/100ps
module cmps_stack_unit
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        use_process_in,
  input  wire logic        load_main_in,
  input  wire logic        write_main_in,
  input  wire logic        write_process_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        push_in,
  input  wire logic        pop_in,
  output logic [31:0]      main_sp_out,
  output logic [31:0]      process_sp_out,
  output logic [31:0]      push_addr_out
);

  logic [31:0] next_main;
  logic [31:0] next_proc;
  logic [31:0] active_sp;
  logic [31:0] dec_sp;
  logic [31:0] inc_sp;

  assign active_sp     = use_process_in ? process_sp_out : main_sp_out;
  assign dec_sp        = active_sp - cmps_pkg::WORD_BYTES;
  assign inc_sp        = active_sp + cmps_pkg::WORD_BYTES;
  // item lands at the already decremented address
  assign push_addr_out = dec_sp;

  always_comb
  begin
    next_main = main_sp_out;
    next_proc = process_sp_out;
    if (load_main_in || write_main_in)
      next_main = {wdata_in[31:2], 2'b00};
    else if (push_in && !use_process_in)
      next_main = dec_sp;
    else if (pop_in && !use_process_in)
      next_main = inc_sp;
    if (write_process_in)
      next_proc = {wdata_in[31:2], 2'b00};
    else if (push_in && use_process_in)
      next_proc = dec_sp;
    else if (pop_in && use_process_in)
      next_proc = inc_sp;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      main_sp_out    <= 32'h0000_0000;
      process_sp_out <= 32'h0000_0000;
    end
    else
    begin
      main_sp_out    <= next_main;
      process_sp_out <= next_proc;
    end
  end

endmodule : cmps_stack_unit

// *** hw/cmps_core_state.sv ***
// Purpose: modes, privilege, stack choice and status words of a small core
// Assumes: datapath gives event strobes and the mover port, one per cycle
// Notes:   vector words arrive on the fetch port after each fetch request
`timescale 1ns/100ps
module cmps_core_state
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // vector fetch
  output logic             fetch_req_out,
  output logic [31:0]      fetch_addr_out,
  input  wire logic        fetch_ack_in,
  input  wire logic [31:0] fetch_data_in,
  // special register mover
  input  wire logic        sr_write_in,
  input  wire logic        sr_read_in,
  input  wire logic [3:0]  sr_sel_in,
  input  wire logic [31:0] sr_wdata_in,
  output logic [31:0]      sr_rdata_out,
  output logic             sr_denied_out,
  // datapath events
  input  wire logic        flags_we_in,
  input  wire logic [3:0]  flags_in,
  input  wire logic        state_branch_in,
  input  wire logic [31:0] state_target_in,
  input  wire logic        msk_in,
  input  wire logic        msk_disable_in,
  input  wire logic        sys_access_in,
  input  wire logic        trap_in,
  input  wire logic        instr_exec_in,
  input  wire logic        multi_busy_in,
  input  wire logic        push_in,
  input  wire logic        pop_in,
  // exceptions
  input  wire logic        exc_req_in,
  input  wire logic [5:0]  exc_num_in,
  input  wire logic        exc_vec_tbit_in,
  input  wire logic        exc_return_in,
  input  wire logic        exc_ret_thread_in,
  input  wire logic        exc_ret_psp_in,
  input  wire logic [5:0]  exc_ret_num_in,
  input  wire logic        exc_ret_tbit_in,
  // state seen by the datapath
  output logic [31:0]      pc_out,
  output logic             pc_load_out,
  output logic             handler_mode_out,
  output logic             privileged_out,
  output logic             use_process_sp_out,
  output logic [31:0]      main_sp_out,
  output logic [31:0]      process_sp_out,
  output logic [31:0]      push_addr_out,
  output logic             exc_taken_out,
  output logic             restart_out,
  output logic             sys_fault_out,
  output logic             lockup_out,
  output logic             big_endian_data_out
);

  // ==========================================================
  // reset release
  logic rst_n;

  cmps_reset_sync u_rst
  (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .rst_n_out  (rst_n)
  );

  // ==========================================================
  // state
  cmps_pkg::cmps_state_type state;
  cmps_pkg::cmps_state_type next_state;
  logic [3:0]  flags;
  logic [3:0]  next_flags;
  logic [5:0]  exc_num;
  logic [5:0]  next_exc_num;
  logic        tbit;
  logic        next_tbit;
  logic        pmask;
  logic        next_pmask;
  logic        user_level;
  logic        next_user_level;
  logic        stack_sel;
  logic        next_stack_sel;
  logic [31:0] pc;
  logic [31:0] next_pc;
  logic        next_pc_load;
  logic        next_exc_taken;
  logic        next_restart;
  logic        load_main;
  logic        write_main;
  logic        write_process;
  logic        handler;
  logic        priv;
  logic        take_exc;
  logic        exc_allowed;
  logic        sr_wr_ok;
  logic [31:0] rdata;
  logic        deny;

  // derived mode and privilege
  assign handler = (state == cmps_pkg::ST_HANDLER);
  assign priv    = handler || !user_level;
  // mask holds back requested exceptions of configurable priority only, not the supervisor call
  assign exc_allowed = !(pmask && (exc_num_in >= cmps_pkg::EXC_CFG_FIRST));
  // a supervisor call is taken even while the mask is set
  assign take_exc = (exc_req_in && exc_allowed) || trap_in;

  // unprivileged attempts at restricted moves and system blocks
  always_comb
  begin
    deny = 1'b0;
    if (!priv && sr_write_in && (sr_sel_in == cmps_pkg::SEL_MAIN_SP ||
        sr_sel_in == cmps_pkg::SEL_PMASK ||
        sr_sel_in == cmps_pkg::SEL_CONTROL))
      deny = 1'b1;
    if (!priv && (msk_in || sys_access_in))
      deny = 1'b1;
  end
  assign sr_wr_ok = sr_write_in && !deny;

  // ==========================================================
  // sequencer and registers
  always_comb
  begin
    next_state      = state;
    next_flags      = flags;
    next_exc_num    = exc_num;
    next_tbit       = tbit;
    next_pmask      = pmask;
    next_user_level = user_level;
    next_stack_sel  = stack_sel;
    next_pc         = pc;
    next_pc_load    = 1'b0;
    next_exc_taken  = 1'b0;
    next_restart    = 1'b0;
    load_main       = 1'b0;
    write_main      = 1'b0;
    write_process   = 1'b0;
    case (state)
      cmps_pkg::ST_FETCH_SP:
      begin
        if (fetch_ack_in)
        begin
          load_main  = 1'b1;
          next_state = cmps_pkg::ST_FETCH_PC;
        end
      end
      cmps_pkg::ST_FETCH_PC:
      begin
        if (fetch_ack_in)
        begin
          next_pc      = {fetch_data_in[31:1], 1'b0};
          next_tbit    = fetch_data_in[0];
          next_pc_load = 1'b1;
          next_state   = cmps_pkg::ST_RUN;
        end
      end
      cmps_pkg::ST_RUN, cmps_pkg::ST_HANDLER:
      begin
        if (flags_we_in)
          next_flags = flags_in;
        if (state_branch_in)
        begin
          // exchange and pop into pc take bit 0 as state
          next_tbit    = state_target_in[0];
          next_pc      = {state_target_in[31:1], 1'b0};
          next_pc_load = 1'b1;
        end
        if (msk_in && priv)
          next_pmask = msk_disable_in;
        if (sr_wr_ok)
        begin
          case (sr_sel_in)
            // combined words: flags taken, number and state dropped
            cmps_pkg::SEL_PSW, cmps_pkg::SEL_IAPSW,
            cmps_pkg::SEL_EAPSW, cmps_pkg::SEL_FLAGS:
              next_flags = sr_wdata_in[31:28];
            cmps_pkg::SEL_PMASK:
              next_pmask = sr_wdata_in[cmps_pkg::MASK_POS];
            cmps_pkg::SEL_CONTROL:
            begin
              next_user_level = sr_wdata_in[cmps_pkg::USER_POS];
              if (!handler)
                next_stack_sel = sr_wdata_in[cmps_pkg::STACK_POS];
            end
            cmps_pkg::SEL_MAIN_SP:
              write_main = 1'b1;
            cmps_pkg::SEL_PROC_SP:
              write_process = 1'b1;
            default:
              next_flags = flags;
          endcase
        end
        if (instr_exec_in && !tbit)
        begin
          // fault inside a handler at or above hard fault locks up
          if (handler && exc_num <= cmps_pkg::EXC_HARD_FAULT)
            next_state = cmps_pkg::ST_LOCKUP;
          else
          begin
            next_state     = cmps_pkg::ST_HANDLER;
            next_exc_num   = cmps_pkg::EXC_HARD_FAULT;
            next_stack_sel = 1'b0;
            next_exc_taken = 1'b1;
          end
        end
        else if (take_exc)
        begin
          next_state     = cmps_pkg::ST_HANDLER;
          next_exc_num   = trap_in ? cmps_pkg::EXC_SUPCALL : exc_num_in;
          next_tbit      = exc_vec_tbit_in;
          next_stack_sel = 1'b0;
          next_exc_taken = 1'b1;
          next_restart   = multi_busy_in;
        end
        else if (exc_return_in && handler)
        begin
          next_tbit      = exc_ret_tbit_in;
          next_stack_sel = exc_ret_thread_in && exc_ret_psp_in;
          next_exc_num   = exc_ret_thread_in ? cmps_pkg::EXC_THREAD
                                             : exc_ret_num_in;
          if (exc_ret_thread_in)
            next_state = cmps_pkg::ST_RUN;
        end
      end
      cmps_pkg::ST_LOCKUP:
        next_state = cmps_pkg::ST_LOCKUP;
      default:
        next_state = cmps_pkg::ST_FETCH_SP;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state         <= cmps_pkg::ST_FETCH_SP;
      flags         <= 4'h0;
      exc_num       <= 6'h00;
      tbit          <= 1'b0;
      pmask         <= 1'b0;
      user_level    <= 1'b0;
      stack_sel     <= 1'b0;
      pc            <= 32'h0000_0000;
      pc_load_out   <= 1'b0;
      exc_taken_out <= 1'b0;
      restart_out   <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      flags         <= next_flags;
      exc_num       <= next_exc_num;
      tbit          <= next_tbit;
      pmask         <= next_pmask;
      user_level    <= next_user_level;
      stack_sel     <= next_stack_sel;
      pc            <= next_pc;
      pc_load_out   <= next_pc_load;
      exc_taken_out <= next_exc_taken;
      restart_out   <= next_restart;
    end
  end

  // ==========================================================
  // stacks
  cmps_stack_unit u_stack
  (
    .sys_clk_in       (sys_clk_in),
    .rst_n_in         (rst_n),
    .use_process_in   (use_process_sp_out),
    .load_main_in     (load_main),
    .write_main_in    (write_main),
    .write_process_in (write_process),
    .wdata_in         (load_main ? fetch_data_in : sr_wdata_in),
    .push_in          (push_in),
    .pop_in           (pop_in),
    .main_sp_out      (main_sp_out),
    .process_sp_out   (process_sp_out),
    .push_addr_out    (push_addr_out)
  );

  // ==========================================================
  // read path
  always_comb
  begin
    rdata = 32'h0000_0000;
    case (sr_sel_in)
      cmps_pkg::SEL_PSW, cmps_pkg::SEL_IAPSW:
        rdata = {flags, 22'h000000, exc_num};
      cmps_pkg::SEL_IEPSW, cmps_pkg::SEL_EXCNUM:
        rdata = {26'h0000000, exc_num};
      cmps_pkg::SEL_EAPSW, cmps_pkg::SEL_FLAGS:
        rdata = {flags, 28'h0000000};
      cmps_pkg::SEL_EXECST:
        rdata = 32'h0000_0000;
      cmps_pkg::SEL_PMASK:
        rdata = {31'h00000000, pmask};
      cmps_pkg::SEL_CONTROL:
        rdata = {30'h00000000, stack_sel && !handler, user_level};
      cmps_pkg::SEL_MAIN_SP:
        rdata = priv ? main_sp_out : 32'h0000_0000;
      cmps_pkg::SEL_PROC_SP:
        rdata = process_sp_out;
      default:
        rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sr_rdata_out  <= 32'h0000_0000;
      sr_denied_out <= 1'b0;
    end
    else
    begin
      sr_rdata_out  <= sr_read_in ? rdata : sr_rdata_out;
      sr_denied_out <= deny;
    end
  end

  // ==========================================================
  // outputs
  assign fetch_req_out  = (state == cmps_pkg::ST_FETCH_SP) ||
                          (state == cmps_pkg::ST_FETCH_PC);
  assign fetch_addr_out = (state == cmps_pkg::ST_FETCH_SP) ?
                          cmps_pkg::VEC_SP_ADDR : cmps_pkg::VEC_RESET_ADDR;
  assign pc_out             = pc;
  assign handler_mode_out   = handler;
  assign privileged_out     = priv;
  assign use_process_sp_out = !handler && stack_sel;
  assign sys_fault_out      = sr_denied_out;
  assign lockup_out         = (state == cmps_pkg::ST_LOCKUP);
  // data and fetch both stay little endian
  assign big_endian_data_out = 1'b0;

endmodule : cmps_core_state

// *** sim/cmps_core_state_checker.sv ***
// Purpose: port level checks for cmps_core_state
// Assumes: bound to the top module, single clock domain
// Notes:   mode, stack and status read checks gated off while vectors are fetched or core locked up
`timescale 1ns/100ps
module cmps_core_state_checker
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        fetch_req_out,
  input  wire logic [31:0] fetch_addr_out,
  input  wire logic        fetch_ack_in,
  input  wire logic [31:0] fetch_data_in,
  input  wire logic        sr_read_in,
  input  wire logic [3:0]  sr_sel_in,
  input  wire logic [31:0] sr_rdata_out,
  input  wire logic        trap_in,
  input  wire logic        instr_exec_in,
  input  wire logic        handler_mode_out,
  input  wire logic        privileged_out,
  input  wire logic        use_process_sp_out,
  input  wire logic [31:0] main_sp_out,
  input  wire logic [31:0] process_sp_out,
  input  wire logic [31:0] push_addr_out,
  input  wire logic        exc_taken_out,
  input  wire logic        lockup_out,
  input  wire logic        big_endian_data_out
);
  logic        live;
  logic [31:0] active_sp;
  // gated checks only sample in run and handler states
  assign live      = !fetch_req_out && !lockup_out;
  assign active_sp = use_process_sp_out ? process_sp_out : main_sp_out;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // vector fetch
  sequence seq_sp_taken;
    fetch_req_out && fetch_addr_out == 32'h0 && fetch_ack_in;
  endsequence
  sequence seq_pc_taken;
    fetch_req_out && fetch_addr_out == 32'h4 && fetch_ack_in;
  endsequence
  chk_sp_vector:
    assert property (seq_sp_taken |=>
      main_sp_out == ($past(fetch_data_in) & 32'hffff_fffc))
    else $error("main pointer not loaded");
  chk_run_thread:
    assert property (seq_sp_taken ##1 seq_pc_taken |=>
      !fetch_req_out && !handler_mode_out && privileged_out)
    else $error("no privileged thread start");
  // ==========================================================
  // modes and stacks
  chk_handler_priv:
    assert property (live && handler_mode_out |-> privileged_out)
    else $error("handler mode without privilege");
  chk_handler_stack:
    assert property (live && handler_mode_out |-> !use_process_sp_out)
    else $error("handler mode on process stack");
  chk_push_addr:
    assert property (live |-> push_addr_out == active_sp - 32'h4)
    else $error("bad push address");
  chk_trap_entry:
    assert property (live && trap_in && !instr_exec_in |=>
      handler_mode_out && exc_taken_out && privileged_out)
    else $error("supervisor call not taken");
  // ==========================================================
  // status reads
  chk_exec_zero:
    assert property (live && sr_read_in &&
      sr_sel_in == cmps_pkg::SEL_EXECST |=> sr_rdata_out == 32'h0)
    else $error("execution state read not zero");
  chk_flag_resv:
    assert property (live && sr_read_in &&
      sr_sel_in == cmps_pkg::SEL_FLAGS |=> sr_rdata_out[27:0] == 28'h0)
    else $error("reserved flag bits not zero");
  chk_ctrl_handler:
    assert property (live && handler_mode_out && sr_read_in &&
      sr_sel_in == cmps_pkg::SEL_CONTROL |=> sr_rdata_out[1] == 1'b0)
    else $error("stack select not zero in handler");
  chk_little_end:
    assert property (big_endian_data_out == 1'b0)
    else $error("big endian data selected");
endmodule : cmps_core_state_checker

bind cmps_core_state cmps_core_state_checker cmps_core_state_checker_inst
(
  .sys_clk_in, .rst_n_in, .fetch_req_out, .fetch_addr_out, .fetch_ack_in,
  .fetch_data_in, .sr_read_in, .sr_sel_in, .sr_rdata_out, .trap_in,
  .instr_exec_in, .handler_mode_out, .privileged_out, .use_process_sp_out,
  .main_sp_out, .process_sp_out, .push_addr_out, .exc_taken_out,
  .lockup_out, .big_endian_data_out
);

// *** sim/tb_top.sv ***
// Purpose: self-checking bench for cmps_core_state
// Assumes: inputs driven at falling edge, vectors answered on fixed cycles
// Notes:   reset and mover rows first, then modes, faults and a closing reset out of lockup
`timescale 1ns/100ps
module tb_top;
  typedef struct {logic [3:0] sel; logic [31:0] wd; logic [31:0] rd;}
    cmps_row_type;
  logic        sys_clk_in, rst_n_in, fetch_ack_in, sr_write_in, sr_read_in;
  logic        flags_we_in, state_branch_in, msk_in, msk_disable_in;
  logic        sys_access_in, trap_in, instr_exec_in, multi_busy_in;
  logic        push_in, pop_in, exc_req_in, exc_vec_tbit_in, exc_return_in;
  logic        exc_ret_thread_in, exc_ret_psp_in, exc_ret_tbit_in;
  logic [3:0]  sr_sel_in, flags_in;
  logic [5:0]  exc_num_in, exc_ret_num_in;
  logic [31:0] fetch_data_in, sr_wdata_in, state_target_in;
  logic        fetch_req_out, sr_denied_out, pc_load_out, handler_mode_out;
  logic        privileged_out, use_process_sp_out, exc_taken_out;
  logic        restart_out, sys_fault_out, lockup_out, big_endian_data_out;
  logic [31:0] fetch_addr_out, sr_rdata_out, pc_out, main_sp_out;
  logic [31:0] process_sp_out, push_addr_out;
  logic        seen_taken, seen_denied, seen_rst, seen_fault;
  int          err_count, tests_run;
  cmps_row_type rows [9] = '{
    '{cmps_pkg::SEL_FLAGS,  32'hffff_ffff, 32'hf000_0000},
    '{cmps_pkg::SEL_PSW,    32'hf100_003f, 32'hf000_0000},
    '{cmps_pkg::SEL_IAPSW,  32'h5000_003f, 32'h5000_0000},
    '{cmps_pkg::SEL_EAPSW,  32'h3100_0000, 32'h3000_0000},
    '{cmps_pkg::SEL_EXECST, 32'hffff_ffff, 32'h0000_0000},
    '{cmps_pkg::SEL_EXCNUM, 32'hffff_ffff, 32'h0000_0000},
    '{cmps_pkg::SEL_PMASK,  32'hffff_ffff, 32'h0000_0001},
    '{cmps_pkg::SEL_PMASK,  32'h0000_0000, 32'h0000_0000},
    '{cmps_pkg::SEL_PROC_SP, 32'h2000_0803, 32'h2000_0800}};

  cmps_core_state cmps_core_state_inst
  (
    .sys_clk_in, .rst_n_in, .fetch_req_out, .fetch_addr_out, .fetch_ack_in,
    .fetch_data_in, .sr_write_in, .sr_read_in, .sr_sel_in, .sr_wdata_in,
    .sr_rdata_out, .sr_denied_out, .flags_we_in, .flags_in,
    .state_branch_in, .state_target_in, .msk_in, .msk_disable_in,
    .sys_access_in, .trap_in, .instr_exec_in, .multi_busy_in, .push_in,
    .pop_in, .exc_req_in, .exc_num_in, .exc_vec_tbit_in, .exc_return_in,
    .exc_ret_thread_in, .exc_ret_psp_in, .exc_ret_num_in, .exc_ret_tbit_in,
    .pc_out, .pc_load_out, .handler_mode_out, .privileged_out,
    .use_process_sp_out, .main_sp_out, .process_sp_out, .push_addr_out,
    .exc_taken_out, .restart_out, .sys_fault_out, .lockup_out,
    .big_endian_data_out
  );

  initial sys_clk_in = 1'b0;
  always #2.5 sys_clk_in = ~sys_clk_in;

  // ==========================================================
  // helpers
  task automatic nx(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : nx

  task automatic chk_word(input string name, input logic [31:0] exp,
                          input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  // one sampling edge, latch the one-cycle pulses, then a quiet cycle
  task automatic fire;
    nx(1);
    seen_taken  = exc_taken_out;
    seen_denied = sr_denied_out;
    seen_rst    = restart_out;
    seen_fault  = sys_fault_out;
    {sr_write_in, sr_read_in, trap_in, exc_req_in, exc_return_in} = '0;
    {msk_in, sys_access_in, instr_exec_in, push_in, pop_in} = '0;
    {flags_we_in, state_branch_in, multi_busy_in} = '0;
    nx(1);
  endtask : fire

  task automatic sr_op(input logic wr, input logic [3:0] sel,
                       input logic [31:0] d);
    sr_write_in = wr;
    sr_read_in  = !wr;
    sr_sel_in   = sel;
    sr_wdata_in = d;
    fire;
  endtask : sr_op

  task automatic exc(input logic [5:0] n);
    exc_req_in      = 1'b1;
    exc_num_in      = n;
    exc_vec_tbit_in = 1'b1;
    fire;
  endtask : exc

  task automatic ret(input logic process_stack_pointer);
    exc_return_in     = 1'b1;
    exc_ret_thread_in = 1'b1;
    exc_ret_psp_in    = process_stack_pointer;
    exc_ret_num_in    = 6'h00;
    exc_ret_tbit_in   = 1'b1;
    fire;
  endtask : ret

  task automatic do_reset;
    rst_n_in = 1'b0;
    nx(6);
    chk_word("fetch addr0", 32'h0, fetch_addr_out);
    rst_n_in = 1'b1;
    nx(2);
    fetch_ack_in  = 1'b1;
    fetch_data_in = 32'h2000_1003;
    nx(1);
    chk_word("fetch addr4", 32'h4, fetch_addr_out);
    fetch_data_in = 32'h0000_0101;
    nx(1);
    fetch_ack_in = 1'b0;
    chk_word("main", 32'h2000_1000, main_sp_out);
    chk_bit("fetching", 1'b0, fetch_req_out);
    chk_bit("thread", 1'b0, handler_mode_out);
    chk_word("pc", 32'h100, pc_out & 32'hffff_fffe);
    chk_bit("pc load", 1'b1, pc_load_out);
    sr_op(1'b0, cmps_pkg::SEL_CONTROL, 32'h0);
    chk_word("control rst", 32'h0, sr_rdata_out);
    $display("test reset done");
  endtask : do_reset

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // ==========================================================
  // main sequence
  initial
  begin
    {fetch_ack_in, sr_write_in, sr_read_in, flags_we_in, msk_in} = '0;
    {state_branch_in, msk_disable_in, sys_access_in, trap_in} = '0;
    {instr_exec_in, multi_busy_in, push_in, pop_in, exc_req_in} = '0;
    {exc_vec_tbit_in, exc_return_in, exc_ret_thread_in} = '0;
    {exc_ret_psp_in, exc_ret_tbit_in, sr_sel_in, flags_in} = '0;
    {exc_num_in, exc_ret_num_in, fetch_data_in} = '0;
    {sr_wdata_in, state_target_in} = '0;
    err_count = 0;
    tests_run = 0;
    do_reset;
    foreach (rows[i])
    begin
      sr_op(1'b1, rows[i].sel, rows[i].wd);
      sr_op(1'b0, rows[i].sel, 32'h0);
      chk_word("row", rows[i].rd, sr_rdata_out);
    end
    $display("test mover rows done");
    flags_we_in = 1'b1;
    flags_in    = 4'h9;
    fire;
    sr_op(1'b0, cmps_pkg::SEL_FLAGS, 32'h0);
    chk_word("flags", 32'h9000_0000, sr_rdata_out);
    sr_op(1'b1, cmps_pkg::SEL_CONTROL, 32'h2);
    chk_bit("proc on", 1'b1, use_process_sp_out);
    chk_word("push addr", 32'h2000_07fc, push_addr_out);
    push_in = 1'b1;
    fire;
    chk_word("proc push", 32'h2000_07fc, process_sp_out);
    pop_in = 1'b1;
    fire;
    chk_word("proc pop", 32'h2000_0800, process_sp_out);
    $display("test stacks done");
    exc(6'd16);
    chk_bit("taken", 1'b1, seen_taken);
    chk_bit("handler", 1'b1, handler_mode_out);
    chk_bit("main handler", 1'b0, use_process_sp_out);
    sr_op(1'b0, cmps_pkg::SEL_EXCNUM, 32'h0);
    chk_word("excnum irq", 32'h10, sr_rdata_out);
    sr_op(1'b1, cmps_pkg::SEL_CONTROL, 32'h2);
    sr_op(1'b0, cmps_pkg::SEL_CONTROL, 32'h0);
    chk_word("ctrl handler", 32'h0, sr_rdata_out);
    ret(1'b1);
    chk_bit("back thread", 1'b0, handler_mode_out);
    chk_bit("proc back", 1'b1, use_process_sp_out);
    sr_op(1'b1, cmps_pkg::SEL_PMASK, 32'h1);
    exc(6'd16);
    chk_bit("masked", 1'b0, handler_mode_out);
    exc(6'd2);
    chk_bit("nmi unmasked", 1'b1, handler_mode_out);
    ret(1'b1);
    sr_op(1'b1, cmps_pkg::SEL_PMASK, 32'h0);
    multi_busy_in = 1'b1;
    exc(6'd17);
    chk_bit("restart", 1'b1, seen_rst);
    ret(1'b1);
    $display("test exceptions done");
    sr_op(1'b1, cmps_pkg::SEL_CONTROL, 32'h3);
    chk_bit("unpriv", 1'b0, privileged_out);
    sr_op(1'b1, cmps_pkg::SEL_PMASK, 32'h1);
    chk_bit("pmask denied", 1'b1, seen_denied);
    sr_op(1'b0, cmps_pkg::SEL_PMASK, 32'h0);
    chk_word("pmask kept", 32'h0, sr_rdata_out);
    sys_access_in = 1'b1;
    fire;
    chk_bit("sys fault", 1'b1, seen_fault);
    msk_in         = 1'b1;
    msk_disable_in = 1'b1;
    fire;
    chk_bit("msk denied", 1'b1, seen_denied);
    sr_op(1'b1, cmps_pkg::SEL_CONTROL, 32'h0);
    chk_bit("still unpriv", 1'b0, privileged_out);
    trap_in = 1'b1;
    fire;
    chk_bit("trap priv", 1'b1, privileged_out);
    sr_op(1'b0, cmps_pkg::SEL_EXCNUM, 32'h0);
    chk_word("excnum trap", 32'h0b, sr_rdata_out);
    sr_op(1'b1, cmps_pkg::SEL_CONTROL, 32'h0);
    ret(1'b0);
    chk_bit("priv again", 1'b1, privileged_out);
    $display("test privilege done");
    state_branch_in = 1'b1;
    state_target_in = 32'h0000_0200;
    fire;
    chk_word("branch pc", 32'h200, pc_out);
    instr_exec_in = 1'b1;
    fire;
    sr_op(1'b0, cmps_pkg::SEL_EXCNUM, 32'h0);
    chk_word("excnum fault", 32'h03, sr_rdata_out);
    instr_exec_in = 1'b1;
    fire;
    chk_bit("lockup", 1'b1, lockup_out);
    $display("test state bit done");
    do_reset;
    chk_bit("lockup cleared", 1'b0, lockup_out);
    test_done;
  end

  // whole run is about 120 cycles
  initial
  begin
    #20000;
    err_count++;
    test_done;
  end
endmodule : tb_top
